//--- sawdt_regs.svh
`ifndef SAWDT_REGS_SVH
`define SAWDT_REGS_SVH

// register byte offsets
`define SAWDT_CTRL_OFS 8'h00
`define SAWDT_PSTAT_OFS 8'h04
`define SAWDT_ISTAT_OFS 8'h08
`define SAWDT_IMASK_OFS 8'h0C
`define SAWDT_COUNT_OFS 8'h10

// control register fields
`define SAWDT_SWEN_BIT 0
`define SAWDT_SEL_LSB 1
`define SAWDT_SEL_MSB 5
`define SAWDT_SEL_MAX 5'h12
`define SAWDT_SEL_RST 5'h0B
`define SAWDT_SWEN_RST 1'h0

// processor status fields, both active low
`define SAWDT_EXPIRY_BIT 4
`define SAWDT_PDOWN_BIT 3
`define SAWDT_FLAG_RST 1'h1

// second configuration word mode field
`define SAWDT_MODE_HI_BIT 3
`define SAWDT_MODE_LO_BIT 2

// counter and prescale
`define SAWDT_CNT_W 23
`define SAWDT_BASE_LOG2 5

// interrupt events
`define SAWDT_EV_N 2
`define SAWDT_EV_RESET 0
`define SAWDT_EV_WAKE 1
`define SAWDT_MASK_RST 2'h0

`endif

//--- sawdt_pkg.sv
`include "sawdt_regs.svh"

package sawdt_pkg;

  typedef enum logic [1:0] {
    SAWDT_MODE_OFF = 2'h0,
    SAWDT_MODE_SW = 2'h1,
    SAWDT_MODE_AWAKE = 2'h2,
    SAWDT_MODE_ON = 2'h3
  } sawdt_mode_t;

  typedef struct packed {
    logic [4:0] period_select;
    logic software_enable;
    logic expiry_flag_n;
    logic powerdown_flag_n;
    logic [`SAWDT_CNT_W-1:0] watchdog_counter;
    logic sleep_q;
    logic reset_pulse;
    logic wake_pulse;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sawdt_state_t;

  typedef struct packed {
    logic [`SAWDT_EV_N-1:0] status;
    logic [`SAWDT_EV_N-1:0] mask;
    logic irq;
  } sawdt_irq_state_t;

endpackage : sawdt_pkg

//--- sawdt_period.sv
`timescale 1ns/1ps
`include "sawdt_regs.svh"

module sawdt_period #(
  parameter int CNT_W = `SAWDT_CNT_W
) (
  input wire logic [4:0] sel_i,
  output logic [CNT_W-1:0] term_o
);

  logic [4:0] eff;

  // reserved codes fall back to the shortest interval
  assign eff = (sel_i > `SAWDT_SEL_MAX) ? 5'h00 : sel_i; // [RQ7]

  // terminal count is 2^(5+sel)-1; one compare per bit, no wide shifter
  genvar i;
  generate
    for (i = 0; i < CNT_W; i++)
    begin : g_term
      assign term_o[i] = (i < (`SAWDT_BASE_LOG2 + int'(eff))); // [RQ6]
    end
  endgenerate

endmodule : sawdt_period

//--- sawdt_irq.sv
`timescale 1ns/1ps
`include "sawdt_regs.svh"

module sawdt_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [`SAWDT_EV_N-1:0] event_i,
  input wire logic [`SAWDT_EV_N-1:0] clear_i,
  input wire logic mask_we_i,
  input wire logic [`SAWDT_EV_N-1:0] mask_i,
  output logic [`SAWDT_EV_N-1:0] status_o,
  output logic [`SAWDT_EV_N-1:0] mask_o,
  output logic irq_o
);

  sawdt_pkg::sawdt_irq_state_t st;
  sawdt_pkg::sawdt_irq_state_t next_st;

  always_comb
  begin
    next_st = st;
    // a new event beats a write-one-to-clear in the same cycle
    next_st.status = event_i | (st.status & ~clear_i);
    if (mask_we_i)
    begin
      next_st.mask = mask_i;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '{status: '0, mask: `SAWDT_MASK_RST, irq: 1'b0};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign mask_o = st.mask;
  assign irq_o = st.irq;

endmodule : sawdt_irq

//--- sawdt_top.sv
// Notes on behaviour
// RQ1: counter clears on reset, clear instruction, sleep entry, wake, osc fail, disable, startup.
// RQ2: sleep entry clears counter; if still enabled it counts on from zero.
// RQ3: sleep exit clears counter; held zero while startup timer runs.
// RQ4: timeout during sleep wakes the device and never resets it.
// RQ5: timeout updates active-low expiry and powerdown flags at bits 4 and 3.
// RQ6: period select bits 5..1; code 0 is 1:32, each step doubles to 1:8388608.
// RQ7: period codes 10011 to 11111 act as the shortest 1:32 interval.
// RQ8: after reset period select is 01011 (1:65536), software enable is zero.
// RQ9: software enable switches watchdog only in mode 01; ignored otherwise.
// RQ10: interval counts low-frequency oscillator cycles, not system clocks.
// RQ11: control bits 7 and 6 always read zero.
// RQ12: mode field is config word bits 3 (high) and 2 (low).
// RQ13: mode 11 always on, 10 off in sleep, 00 always off.
// RQ14: timeout while awake and active raises a device reset.
// RQ15: firmware must clear the watchdog faster than the selected period.
// RQ16: free 23-bit counter; timeout when it reaches the selected terminal count.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "sawdt_regs.svh"

module sawdt_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic LOW_FREQ_OSC_TICK_I,
  input wire logic CLEAR_WATCHDOG_I,
  input wire logic SLEEP_I,
  input wire logic WAKE_INT_I,
  input wire logic OSC_FAIL_I,
  input wire logic OSC_STARTUP_TIMER_RUN_I,
  input wire logic [7:0] SECOND_CONFIG_WORD_I,
  output logic WATCHDOG_RESET_O,
  output logic WAKE_O,
  output logic IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers

  sawdt_pkg::sawdt_state_t st;
  sawdt_pkg::sawdt_state_t next_st;
  sawdt_pkg::sawdt_mode_t mode;
  logic [`SAWDT_CNT_W-1:0] term;
  logic active;
  logic sleep_entry;
  logic sleep_exit;
  logic clear_cnt;
  logic timeout;
  logic bus_write;
  logic bus_read;
  logic addr_ok;
  logic [`SAWDT_EV_N-1:0] ev_status;
  logic [`SAWDT_EV_N-1:0] ev_mask;
  logic [`SAWDT_EV_N-1:0] ev_set;
  logic [`SAWDT_EV_N-1:0] ev_clr;
  logic mask_we;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // mode and enable

  // configuration is static; taken straight from the word each cycle
  assign mode = sawdt_pkg::sawdt_mode_t'({SECOND_CONFIG_WORD_I[`SAWDT_MODE_HI_BIT],
                                          SECOND_CONFIG_WORD_I[`SAWDT_MODE_LO_BIT]}); // [RQ12]

  always_comb
  begin
    case (mode)
      sawdt_pkg::SAWDT_MODE_ON:
      begin
        active = 1'b1; // [RQ13]
      end
      sawdt_pkg::SAWDT_MODE_AWAKE:
      begin
        active = ~SLEEP_I; // [RQ13]
      end
      sawdt_pkg::SAWDT_MODE_SW:
      begin
        active = st.software_enable; // [RQ9]
      end
      default:
      begin
        active = 1'b0; // [RQ13] [RQ9]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescale terminal count

  sawdt_period #(
    .CNT_W(`SAWDT_CNT_W)
  ) u_period (
    .sel_i(st.period_select),
    .term_o(term)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter clear and timeout

  assign sleep_entry = SLEEP_I & ~st.sleep_q;
  assign sleep_exit = ~SLEEP_I & st.sleep_q;

  // startup timer hold also covers the window after wake-up
  assign clear_cnt = CLEAR_WATCHDOG_I | sleep_entry | sleep_exit | WAKE_INT_I
                   | OSC_FAIL_I | ~active | OSC_STARTUP_TIMER_RUN_I; // [RQ1] [RQ2] [RQ3]

  // only oscillator ticks advance time; system clock rate is irrelevant
  assign timeout = ~clear_cnt & LOW_FREQ_OSC_TICK_I
                 & (st.watchdog_counter == term); // [RQ10] [RQ16]

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign bus_write = PSEL_I & PENABLE_I & st.pready & PWRITE_I;
  assign bus_read = PSEL_I & PENABLE_I & ~st.pready & ~PWRITE_I;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (PADDR_I)
      `SAWDT_CTRL_OFS:
      begin
        // upper two bits stay zero
        rd_val[`SAWDT_SEL_MSB:`SAWDT_SEL_LSB] = st.period_select; // [RQ11]
        rd_val[`SAWDT_SWEN_BIT] = st.software_enable;
      end
      `SAWDT_PSTAT_OFS:
      begin
        rd_val[`SAWDT_EXPIRY_BIT] = st.expiry_flag_n;
        rd_val[`SAWDT_PDOWN_BIT] = st.powerdown_flag_n;
      end
      `SAWDT_ISTAT_OFS:
      begin
        rd_val[`SAWDT_EV_N-1:0] = ev_status;
      end
      `SAWDT_IMASK_OFS:
      begin
        rd_val[`SAWDT_EV_N-1:0] = ev_mask;
      end
      `SAWDT_COUNT_OFS:
      begin
        rd_val[`SAWDT_CNT_W-1:0] = st.watchdog_counter;
      end
      default:
      begin
        addr_ok = 1'b0;
      end
    endcase
  end

  assign ev_clr = (bus_write && PADDR_I == `SAWDT_ISTAT_OFS) ?
                  PWDATA_I[`SAWDT_EV_N-1:0] : '0;
  assign mask_we = bus_write && (PADDR_I == `SAWDT_IMASK_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st = st;
    next_st.sleep_q = SLEEP_I;
    next_st.reset_pulse = 1'b0;
    next_st.wake_pulse = 1'b0;

    // one wait state: ready rises the cycle after the access phase starts
    next_st.pready = PSEL_I & PENABLE_I & ~st.pready;
    if (PSEL_I & PENABLE_I & ~st.pready)
    begin
      next_st.pslverr = ~addr_ok;
      next_st.prdata = bus_read ? rd_val : 32'h0000_0000;
    end
    else if (st.pready)
    begin
      next_st.pslverr = 1'b0;
      next_st.prdata = 32'h0000_0000;
    end

    if (bus_write && PADDR_I == `SAWDT_CTRL_OFS)
    begin
      next_st.period_select = PWDATA_I[`SAWDT_SEL_MSB:`SAWDT_SEL_LSB]; // [RQ6]
      next_st.software_enable = PWDATA_I[`SAWDT_SWEN_BIT];
    end

    // counter
    if (clear_cnt)
    begin
      next_st.watchdog_counter = '0; // [RQ1] [RQ3]
    end
    else if (timeout)
    begin
      next_st.watchdog_counter = '0; // [RQ16]
    end
    else if (LOW_FREQ_OSC_TICK_I)
    begin
      next_st.watchdog_counter = st.watchdog_counter + 1'b1; // [RQ2] [RQ10]
    end

    // status flags
    if (CLEAR_WATCHDOG_I)
    begin
      next_st.expiry_flag_n = 1'b1;
      next_st.powerdown_flag_n = 1'b1;
    end
    if (sleep_entry)
    begin
      next_st.expiry_flag_n = 1'b1;
      next_st.powerdown_flag_n = 1'b0;
    end
    if (timeout)
    begin
      next_st.expiry_flag_n = 1'b0; // [RQ5]
      if (SLEEP_I)
      begin
        next_st.powerdown_flag_n = 1'b0; // [RQ5]
        next_st.wake_pulse = 1'b1; // [RQ4]
      end
      else
      begin
        next_st.reset_pulse = 1'b1; // [RQ14]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st <= '{period_select: `SAWDT_SEL_RST,
              software_enable: `SAWDT_SWEN_RST,
              expiry_flag_n: `SAWDT_FLAG_RST,
              powerdown_flag_n: `SAWDT_FLAG_RST,
              watchdog_counter: '0,
              sleep_q: 1'b0,
              reset_pulse: 1'b0,
              wake_pulse: 1'b0,
              pready: 1'b0,
              pslverr: 1'b0,
              prdata: 32'h0000_0000}; // [RQ8] [RQ1]
    end
    else if (CE_I)
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign ev_set = {timeout & SLEEP_I, timeout & ~SLEEP_I};

  sawdt_irq u_irq (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .event_i(ev_set),
    .clear_i(ev_clr),
    .mask_we_i(mask_we),
    .mask_i(PWDATA_I[`SAWDT_EV_N-1:0]),
    .status_o(ev_status),
    .mask_o(ev_mask),
    .irq_o(IRQ_O)
  );

  assign PRDATA_O = st.prdata;
  assign PREADY_O = st.pready;
  assign PSLVERR_O = st.pslverr;
  assign WATCHDOG_RESET_O = st.reset_pulse;
  assign WAKE_O = st.wake_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  clear_on_instr_a: assert property ( // [RQ1]
    CE_I && CLEAR_WATCHDOG_I |=> st.watchdog_counter == '0)
    else $error("counter not cleared by clear instruction");

  sleep_entry_clear_a: assert property ( // [RQ2]
    CE_I && SLEEP_I && !st.sleep_q |=> st.watchdog_counter == '0 && !st.powerdown_flag_n)
    else $error("sleep entry did not clear counter");

  startup_hold_a: assert property ( // [RQ3]
    CE_I && OSC_STARTUP_TIMER_RUN_I |=> st.watchdog_counter == '0)
    else $error("counter moved while startup timer runs");

  sleep_no_reset_a: assert property ( // [RQ4]
    CE_I && timeout && SLEEP_I |=> WAKE_O && !WATCHDOG_RESET_O)
    else $error("sleep timeout gave reset instead of wake");

  expiry_flag_a: assert property ( // [RQ5]
    CE_I && timeout |=> !st.expiry_flag_n)
    else $error("expiry flag not lowered on timeout");

  reserved_min_a: assert property ( // [RQ7]
    st.period_select > `SAWDT_SEL_MAX |-> term == 23'h00_001F)
    else $error("reserved period code not shortest");

  mode_off_a: assert property ( // [RQ9]
    mode == sawdt_pkg::SAWDT_MODE_OFF |-> !active)
    else $error("watchdog active with mode 00");

  tick_only_a: assert property ( // [RQ10]
    CE_I && !LOW_FREQ_OSC_TICK_I && !clear_cnt |=> $stable(st.watchdog_counter))
    else $error("counter advanced without oscillator tick");

  ctrl_upper_a: assert property ( // [RQ11]
    PREADY_O && !PSLVERR_O && $past(PADDR_I) == `SAWDT_CTRL_OFS |-> PRDATA_O[7:6] == 2'b00)
    else $error("control upper bits not zero");

  awake_reset_a: assert property ( // [RQ14]
    CE_I && timeout && !SLEEP_I |=> WATCHDOG_RESET_O ##1 !WATCHDOG_RESET_O || !CE_I)
    else $error("awake timeout gave no single reset pulse");

  reset_values_a: assert property ( // [RQ8]
    $fell(RST_I) |-> st.period_select == `SAWDT_SEL_RST && !st.software_enable)
    else $error("control not at reset values after reset");

  sleep_flags_a: assert property ( // [RQ5]
    CE_I && timeout && SLEEP_I |=> !st.expiry_flag_n && !st.powerdown_flag_n)
    else $error("sleep timeout did not lower both flags");

  cov_awake_reset: cover property (WATCHDOG_RESET_O);
  cov_reserved_code: cover property (st.period_select > `SAWDT_SEL_MAX && timeout);
  cov_sleep_wake: cover property (WAKE_O && IRQ_O);
  cov_sw_mode: cover property (mode == sawdt_pkg::SAWDT_MODE_SW && active ##1 timeout);

endmodule : sawdt_top

//--- sawdt_osc_model.sv
`timescale 1ns/1ps

module sawdt_osc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [9:0] num_i,
  input wire logic [1:0] gap_i,
  output logic tick_o,
  output logic busy_o
);
  logic [9:0] left;
  logic [1:0] wait_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // slow oscillator edges as single-cycle pulses, spacing set per burst
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      left <= 10'h000;
      wait_cnt <= 2'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (start_i)
      begin
        left <= num_i;
        wait_cnt <= 2'h0;
      end
      else if (left != 10'h000)
      begin
        if (wait_cnt == 2'h0)
        begin
          tick_o <= 1'b1;
          left <= left - 10'h001;
          wait_cnt <= gap_i;
        end
        else
        begin
          wait_cnt <= wait_cnt - 2'h1;
        end
      end
    end
  end

  // busy covers the last pulse, so the caller never races it
  assign busy_o = (left != 10'h000) | tick_o;
endmodule : sawdt_osc_model

//--- tb.sv
`timescale 1ns/1ps
`include "sawdt_regs.svh"

module tb;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, start = 0;
  logic clr = 0, slp = 0, wint = 0, ofail = 0, oscillator_startup_timer = 0;
  logic [7:0] pa = 0, cfg = 8'h0C;
  logic [31:0] pd = 0, seed = 32'h0001_5127;
  logic [9:0] num = 0;
  logic [1:0] gap = 0;
  logic [31:0] prdata;
  logic pready, pslverr, tick, busy, wdr, wake, irq;
  int failures = 0, total_checks = 0, n_rst = 0, n_wake = 0;
  logic [32:0] expq[$];

  sawdt_top u_dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(pd), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .LOW_FREQ_OSC_TICK_I(tick), .CLEAR_WATCHDOG_I(clr),
    .SLEEP_I(slp), .WAKE_INT_I(wint), .OSC_FAIL_I(ofail), .OSC_STARTUP_TIMER_RUN_I(oscillator_startup_timer),
    .SECOND_CONFIG_WORD_I(cfg), .WATCHDOG_RESET_O(wdr), .WAKE_O(wake), .IRQ_O(irq));

  sawdt_osc_model u_osc (.clk_i(clk), .rst_i(rst), .start_i(start), .num_i(num),
    .gap_i(gap), .tick_o(tick), .busy_o(busy));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int i;
    if (!w)
      expq.push_back(e);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1;
    i = 0;
    // ready is judged at the rising edge that also lands the write
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      failures++;
      conclude();
    end
    psel <= 0;
    pen <= 0;
  endtask : apb

  task ticks(input int n);
    int i;
    @(posedge clk);
    start <= 1;
    num <= n[9:0];
    gap <= 2'(xs());
    @(posedge clk);
    start <= 0;
    i = 0;
    do
    begin
      @(negedge clk);
      i++;
    end
    while (busy !== 1'b0 && i < 5000);
    if (i >= 5000)
    begin
      failures++;
      conclude();
    end
    repeat (3) @(posedge clk);
  endtask : ticks

  task pulses(input int r, input int w);
    chk(33'(n_rst), 33'(r));
    chk(33'(n_wake), 33'(w));
    n_rst = 0;
    n_wake = 0;
  endtask : pulses

  // firmware side events: 0 clear instruction, 1 wake interrupt, 2 osc failure
  task pulse(input int k);
    @(posedge clk);
    clr <= (k == 0);
    wint <= (k == 1);
    ofail <= (k == 2);
    @(posedge clk);
    {clr, wint, ofail} <= 3'h0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  // read results and output pulses, taken at the edge that samples them
  always @(posedge clk)
  begin
    if (pready === 1'b1 && !pw && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
    if (wdr === 1'b1)
      n_rst++;
    if (wake === 1'b1)
      n_wake++;
  end

  initial
  begin
    int s;
    logic [4:0] r;
    repeat (12) @(posedge clk);
    rst <= 0;
    apb(0, `SAWDT_CTRL_OFS, 0, 33'h0_0000_0016);
    apb(0, `SAWDT_PSTAT_OFS, 0, 33'h0_0000_0018);
    apb(0, 8'h14, 0, 33'h1_0000_0000);
    apb(1, `SAWDT_CTRL_OFS, 32'hFFFF_FFFF, 0);
    apb(0, `SAWDT_CTRL_OFS, 0, 33'h0_0000_003F);
    $display("register test done");
    for (s = 0; s < 3; s++)
    begin
      apb(1, `SAWDT_CTRL_OFS, 32'(s << 1), 0);
      ticks((32 << s) - 1);
      pulses(0, 0);
      ticks(1);
      pulses(1, 0);
    end
    r = 5'h13 + 5'(xs() % 13);
    apb(1, `SAWDT_CTRL_OFS, {26'h0, r, 1'h0}, 0);
    apb(0, `SAWDT_CTRL_OFS, 0, {27'h0, r, 1'h0});
    ticks(32);
    pulses(1, 0);
    $display("period test done");
    apb(1, `SAWDT_CTRL_OFS, 0, 0);
    for (s = 0; s < 3; s++)
    begin
      pulse(0);
      ticks(31);
      pulse(s);
      ticks(31);
      pulses(0, 0);
    end
    @(posedge clk);
    oscillator_startup_timer <= 1;
    ticks(40);
    pulses(0, 0);
    @(posedge clk);
    oscillator_startup_timer <= 0;
    $display("clear test done");
    // sticky status, masked, then cleared by a one
    apb(0, `SAWDT_ISTAT_OFS, 0, 33'h0_0000_0001);
    chk({32'h0, irq}, 33'h0);
    // both events unmasked so the sleep wake also shows on the line
    apb(1, `SAWDT_IMASK_OFS, 32'h3, 0);
    repeat (3) @(negedge clk);
    chk({32'h0, irq}, 33'h1);
    apb(1, `SAWDT_ISTAT_OFS, 32'h1, 0);
    repeat (3) @(negedge clk);
    chk({32'h0, irq}, 33'h0);
    apb(0, `SAWDT_ISTAT_OFS, 0, 33'h0_0000_0000);
    $display("interrupt test done");
    @(posedge clk);
    slp <= 1;
    ticks(32);
    pulses(0, 1);
    chk({32'h0, irq}, 33'h1);
    apb(0, `SAWDT_PSTAT_OFS, 0, 33'h0_0000_0000);
    apb(0, `SAWDT_ISTAT_OFS, 0, 33'h0_0000_0002);
    @(posedge clk);
    slp <= 0;
    pulse(0);
    apb(0, `SAWDT_PSTAT_OFS, 0, 33'h0_0000_0018);
    $display("sleep test done");
    @(posedge clk);
    cfg <= 8'h08;
    slp <= 1;
    ticks(40);
    pulses(0, 0);
    @(posedge clk);
    slp <= 0;
    cfg <= 8'h00;
    ticks(40);
    pulses(0, 0);
    @(posedge clk);
    cfg <= 8'h04;
    ticks(40);
    pulses(0, 0);
    apb(1, `SAWDT_CTRL_OFS, 32'h1, 0);
    ticks(32);
    pulses(1, 0);
    pulse(0);
    ticks(5);
    apb(0, `SAWDT_COUNT_OFS, 0, 33'h0_0000_0005);
    $display("mode test done");
    // second reset in mid-run: control back to defaults, counter cleared
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, `SAWDT_CTRL_OFS, 0, 33'h0_0000_0016);
    apb(0, `SAWDT_COUNT_OFS, 0, 33'h0_0000_0000);
    $display("reset test done");
    // let the monitor take the last answer before the verdict
    repeat (2) @(posedge clk);
    chk(33'(expq.size()), 33'h0);
    conclude();
  end
endmodule : tb
